// ===== hdl/ulpi_lp_pkg.sv
// Purpose: Shared constants and types for the ULPI low-power and serial control ends.
// Assumes: 250 MHz reference clock on both ends.
// Notes: Register addresses and bit positions not fixed elsewhere are local picks.
`default_nettype none
package ulpi_lp_pkg;
    localparam int DATA_W = 8;
    localparam int IRQ_W = 4;
    localparam int REF_PERIOD_NS = 4;
    localparam int START_TIME_NS = 1000;
    localparam int CLK_HALF_DIV = 8;
    localparam logic [3:0] SUSPEND_EDGES = 4'h5;

    localparam logic [5:0] FUNC_CTRL_ADDR = 6'h04;
    localparam logic [5:0] IFC_CTRL_ADDR = 6'h07;
    localparam logic [5:0] IRQ_RISE_ADDR = 6'h0D;
    localparam logic [5:0] IRQ_FALL_ADDR = 6'h10;
    localparam int SUSPEND_NOT_BIT = 6;
    localparam int STOP_PULLUP_DISABLE_BIT = 7;
    localparam int CLOCK_KEEP_RUNNING_BIT = 3;
    localparam int SERIAL6_BIT = 0;
    localparam int SERIAL3_BIT = 1;
    localparam int IRQ_VBUS_BIT = 0;
    localparam int IRQ_SESS_END_BIT = 2;
    localparam logic [7:0] FUNC_CTRL_RST = 8'h41;
    localparam logic [7:0] IFC_CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h0F;

    localparam logic [1:0] CMD_TX = 2'h1;
    localparam logic [1:0] CMD_REGW = 2'h2;
    localparam logic [7:0] BUS_IDLE = 8'h00;
    localparam logic [7:0] OE_ALL = 8'hFF;
    localparam logic [7:0] OE_SER3_RX = 8'hFE;
    localparam logic [7:0] OE_SER3_TX = 8'hF8;
    localparam logic [7:0] LINK_OE_SER3_RX = 8'h01;
    localparam logic [7:0] LINK_OE_SER3_TX = 8'h07;

    localparam logic [7:0] LINK_CMD_ADDR = 8'h00;
    localparam logic [7:0] LINK_CTRL_ADDR = 8'h04;
    localparam logic [7:0] LINK_STAT_ADDR = 8'h08;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CTRL_WAKE = 0;
    localparam int CTRL_STP_HOLD = 1;
    localparam int CTRL_STP_FLOAT = 2;
    localparam int CTRL_TX_EN = 3;
    localparam int CTRL_TX_DP = 4;
    localparam int CTRL_TX_SE0 = 5;
    localparam int CTRL_SER3 = 6;
    localparam int CTRL_W = 7;

    typedef enum logic [1:0] {MODE_SYNC, MODE_LOWPWR, MODE_SERIAL3, MODE_SERIAL6} mode_t;
endpackage
`default_nettype wire

// ===== hdl/ulpi_lp_if.sv
// Purpose: ULPI pins between the transceiver end and the link end.
// Assumes: Undriven data bits read low through the weak pull-downs.
// Notes: Stop reads high through the pull-up while the link floats it.
`default_nettype none
interface ulpi_lp_if;
    logic clk;
    logic dir;
    logic nxt;
    logic stp_pullup_en;
    logic link_stp;
    logic link_stp_oe;
    logic stp;
    logic [7:0] dev_data;
    logic [7:0] dev_oe;
    logic [7:0] link_data;
    logic [7:0] link_oe;
    logic [7:0] data;

    assign stp = link_stp_oe ? link_stp : stp_pullup_en;
    assign data = (dev_oe & dev_data) | (link_oe & link_data);

    modport device (output clk, output dir, output nxt, output stp_pullup_en,
                    output dev_data, output dev_oe, input stp, input data);
    modport link (input clk, input dir, input nxt, input data,
                  output link_stp, output link_stp_oe, output link_data, output link_oe);
endinterface
`default_nettype wire

// ===== hdl/sync2.sv
// Purpose: Two flip-flop synchroniser for a vector of levels.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds the second stage only.
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_t;

    sync_t r_reg;
    sync_t r_next;

    always_comb begin
        r_next.meta = d_i;
        r_next.q = r_reg.meta;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q_o = r_reg.q;
endmodule
`default_nettype wire

// ===== hdl/ulpi_lp_device.sv
// Purpose: Transceiver end: suspend exit, interface protection, 3-pin serial mode.
// Assumes: Link samples on interface clock falls, this end on rises.
// Notes: Interface clock is the reference clock divided by 2*CLK_HALF_DIV.
`default_nettype none
module ulpi_lp_device #(
    parameter int START_TIME_NS = ulpi_lp_pkg::START_TIME_NS,
    parameter int CLK_HALF_DIV = ulpi_lp_pkg::CLK_HALF_DIV,
    parameter int IRQ_W = ulpi_lp_pkg::IRQ_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    ulpi_lp_if.device bus,
    input wire logic active_low_reset_pin_i,
    input wire logic [IRQ_W-1:0] irq_src_i,
    input wire logic [1:0] linestate_i,
    input wire logic rx_diff_i,
    input wire logic rx_se0_i,
    output logic usb_tx_en_o,
    output logic usb_tx_dp_o,
    output logic usb_tx_se0_o,
    output logic bus_voltage_valid_comparator_en_o,
    output logic session_end_comparator_en_o,
    output ulpi_lp_pkg::mode_t mode_o,
    output logic suspend_not_o
);
    localparam int START_CYCLES = (START_TIME_NS + ulpi_lp_pkg::REF_PERIOD_NS - 1)
                                  / ulpi_lp_pkg::REF_PERIOD_NS;
    localparam int SYNC_W = IRQ_W + 14;

    typedef enum logic [3:0] {
        D_SYNC, D_REGDATA, D_XMIT, D_RX_TURN, D_RX_CMD,
        D_ENTER, D_PARKED, D_STARTUP, D_RELEASE, D_WAITSTOP
    } dstate_t;

    typedef struct packed {
        dstate_t state;
        ulpi_lp_pkg::mode_t mode;
        logic [7:0] func_ctrl;
        logic [7:0] ifc_ctrl;
        logic [7:0] irq_rise;
        logic [7:0] irq_fall;
        logic [IRQ_W-1:0] snap;
        logic [5:0] addr;
        logic [15:0] cnt;
        logic [7:0] div;
        logic clk_lvl;
        logic clk_run;
        logic dir;
        logic dir_prev;
        logic nxt;
        logic [7:0] dout;
        logic [1:0] ls_last;
        logic tx_en;
        logic tx_dp;
        logic tx_se0;
    } dev_t;

    localparam dev_t DEV_RST = '{
        state: D_SYNC, mode: ulpi_lp_pkg::MODE_SYNC,
        func_ctrl: ulpi_lp_pkg::FUNC_CTRL_RST, ifc_ctrl: ulpi_lp_pkg::IFC_CTRL_RST,
        irq_rise: ulpi_lp_pkg::IRQ_EN_RST, irq_fall: ulpi_lp_pkg::IRQ_EN_RST,
        clk_run: 1'b1, default: '0};

    dev_t r_reg;
    dev_t r_next;
    logic [SYNC_W-1:0] sync_q;
    logic stp_s;
    logic rstpin_s;
    logic rx_diff_s;
    logic rx_se0_s;
    logic [7:0] data_s;
    logic [IRQ_W-1:0] irq_s;
    logic [1:0] ls_s;
    logic [IRQ_W-1:0] irq_mask;
    logic irq_hit;
    logic rise;
    logic fall;

    sync2 #(.W(SYNC_W)) in_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i({bus.stp, active_low_reset_pin_i, rx_diff_i, rx_se0_i, bus.data,
              irq_src_i, linestate_i}),
        .q_o(sync_q)
    );
    assign {stp_s, rstpin_s, rx_diff_s, rx_se0_s, data_s, irq_s, ls_s} = sync_q;

    assign irq_mask = r_reg.irq_rise[IRQ_W-1:0] | r_reg.irq_fall[IRQ_W-1:0];
    assign irq_hit = |((irq_s ^ r_reg.snap) & irq_mask);
    assign rise = r_reg.clk_run && r_reg.div == 8'(CLK_HALF_DIV - 1) && !r_reg.clk_lvl;
    assign fall = r_reg.clk_run && r_reg.div == 8'(CLK_HALF_DIV - 1) && r_reg.clk_lvl;

    always_comb begin
        r_next = r_reg;
        if (r_reg.clk_run) begin
            if (r_reg.div == 8'(CLK_HALF_DIV - 1)) begin
                r_next.div = '0;
                r_next.clk_lvl = ~r_reg.clk_lvl;
            end else begin
                r_next.div = r_reg.div + 8'h01;
            end
        end else begin
            r_next.div = '0;
            r_next.clk_lvl = 1'b0;
        end
        if (rise) begin
            r_next.dir_prev = r_reg.dir;
        end
        r_next.tx_en = 1'b0;
        r_next.tx_dp = 1'b0;
        r_next.tx_se0 = 1'b0;
        case (r_reg.state)
            D_SYNC: begin
                r_next.dout = ulpi_lp_pkg::BUS_IDLE;
                if (rise) begin
                    if (!r_reg.func_ctrl[ulpi_lp_pkg::SUSPEND_NOT_BIT]) begin
                        r_next.mode = ulpi_lp_pkg::MODE_LOWPWR;
                    end else if (r_reg.ifc_ctrl[ulpi_lp_pkg::SERIAL3_BIT]) begin
                        r_next.mode = ulpi_lp_pkg::MODE_SERIAL3;
                    end else if (r_reg.ifc_ctrl[ulpi_lp_pkg::SERIAL6_BIT]) begin
                        r_next.mode = ulpi_lp_pkg::MODE_SERIAL6;
                    end
                    if (r_next.mode != ulpi_lp_pkg::MODE_SYNC) begin
                        r_next.snap = irq_s;
                        r_next.dir = 1'b1;
                        r_next.cnt = '0;
                        r_next.state = D_ENTER;
                    end else if (data_s[7:6] == ulpi_lp_pkg::CMD_REGW) begin
                        r_next.addr = data_s[5:0];
                        r_next.nxt = 1'b1;
                        r_next.state = D_REGDATA;
                    end else if (data_s[7:6] == ulpi_lp_pkg::CMD_TX) begin
                        r_next.nxt = 1'b1;
                        r_next.state = D_XMIT;
                    end else if (ls_s != r_reg.ls_last) begin
                        r_next.dir = 1'b1;
                        r_next.state = D_RX_TURN;
                    end
                end
            end
            D_REGDATA: begin
                if (rise) begin
                    r_next.nxt = 1'b0;
                    r_next.state = D_SYNC;
                    case (r_reg.addr)
                        ulpi_lp_pkg::FUNC_CTRL_ADDR: r_next.func_ctrl = data_s;
                        ulpi_lp_pkg::IFC_CTRL_ADDR: r_next.ifc_ctrl = data_s;
                        ulpi_lp_pkg::IRQ_RISE_ADDR: r_next.irq_rise = data_s;
                        ulpi_lp_pkg::IRQ_FALL_ADDR: r_next.irq_fall = data_s;
                        default: r_next.state = D_SYNC;
                    endcase
                end
            end
            D_XMIT: begin
                r_next.tx_en = 1'b1;
                if (rise && stp_s) begin
                    r_next.nxt = 1'b0;
                    r_next.state = D_SYNC;
                end
            end
            D_RX_TURN: begin
                if (rise) begin
                    r_next.dout = {6'h00, ls_s};
                    r_next.ls_last = ls_s;
                    r_next.state = D_RX_CMD;
                end
            end
            D_RX_CMD: begin
                if (rise) begin
                    r_next.dir = 1'b0;
                    r_next.state = D_SYNC;
                end
            end
            D_ENTER: begin
                if (rise && r_reg.cnt < 16'(ulpi_lp_pkg::SUSPEND_EDGES)) begin
                    r_next.cnt = r_reg.cnt + 16'h0001;
                end
                if (fall && r_reg.cnt >= 16'(ulpi_lp_pkg::SUSPEND_EDGES)) begin
                    // Keep-running only applies to the serial modes
                    r_next.clk_run = r_reg.mode != ulpi_lp_pkg::MODE_LOWPWR
                        && r_reg.ifc_ctrl[ulpi_lp_pkg::CLOCK_KEEP_RUNNING_BIT];
                    r_next.state = D_PARKED;
                end
            end
            D_PARKED: begin
                if (stp_s) begin
                    r_next.cnt = '0;
                    r_next.state = D_STARTUP;
                end
            end
            D_STARTUP: begin
                r_next.cnt = r_reg.cnt + 16'h0001;
                if (!stp_s) begin
                    r_next.state = D_PARKED;
                end else if (r_reg.cnt >= 16'(START_CYCLES - 1)) begin
                    r_next.clk_run = 1'b1;
                    r_next.state = D_RELEASE;
                end
            end
            D_RELEASE: begin
                if (rise) begin
                    if (!stp_s) begin
                        r_next.cnt = '0;
                        r_next.state = D_ENTER;
                    end else begin
                        r_next.dir = 1'b0;
                        r_next.mode = ulpi_lp_pkg::MODE_SYNC;
                        r_next.func_ctrl[ulpi_lp_pkg::SUSPEND_NOT_BIT] = 1'b1;
                        r_next.ifc_ctrl[ulpi_lp_pkg::SERIAL3_BIT] = 1'b0;
                        r_next.ifc_ctrl[ulpi_lp_pkg::SERIAL6_BIT] = 1'b0;
                        r_next.dout = ulpi_lp_pkg::BUS_IDLE;
                        r_next.state = D_WAITSTOP;
                    end
                end
            end
            D_WAITSTOP: begin
                if (rise && !stp_s) begin
                    r_next.state = D_SYNC;
                end
            end
            default: r_next.state = D_SYNC;
        endcase
        if (r_reg.state inside {D_ENTER, D_PARKED, D_STARTUP}
            || (r_reg.state == D_RELEASE && r_reg.dir)) begin
            case (r_reg.mode)
                ulpi_lp_pkg::MODE_LOWPWR: r_next.dout = {4'h0, irq_hit, 1'b0, ls_s};
                ulpi_lp_pkg::MODE_SERIAL3: begin
                    r_next.dout = {4'h0, irq_hit, ~rx_se0_s, rx_diff_s, 1'b0};
                    r_next.tx_en = data_s[0];
                    r_next.tx_dp = data_s[0] & data_s[1];
                    r_next.tx_se0 = data_s[0] & data_s[2];
                end
                default: r_next.dout = {4'h0, irq_hit, 3'h0};
            endcase
        end
        if (!rstpin_s) begin
            r_next = DEV_RST;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= DEV_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Data lanes stay released for the turnaround clock after direction rises
    always_comb begin
        bus.dev_oe = '0;
        if (r_reg.dir && r_reg.dir_prev) begin
            if (r_reg.mode == ulpi_lp_pkg::MODE_SERIAL3 && r_reg.state != D_WAITSTOP) begin
                bus.dev_oe = data_s[0] ? ulpi_lp_pkg::OE_SER3_TX
                                       : ulpi_lp_pkg::OE_SER3_RX;
            end else begin
                bus.dev_oe = ulpi_lp_pkg::OE_ALL;
            end
        end
    end

    assign bus.clk = r_reg.clk_lvl;
    assign bus.dir = r_reg.dir;
    assign bus.nxt = r_reg.nxt;
    assign bus.dev_data = r_reg.dout;
    // Pull-up follows the disable bit and is off while the reset pin is low
    assign bus.stp_pullup_en = rstpin_s
        && !r_reg.ifc_ctrl[ulpi_lp_pkg::STOP_PULLUP_DISABLE_BIT];
    assign bus_voltage_valid_comparator_en_o = r_reg.irq_rise[ulpi_lp_pkg::IRQ_VBUS_BIT]
        | r_reg.irq_fall[ulpi_lp_pkg::IRQ_VBUS_BIT];
    assign session_end_comparator_en_o = r_reg.irq_rise[ulpi_lp_pkg::IRQ_SESS_END_BIT]
        | r_reg.irq_fall[ulpi_lp_pkg::IRQ_SESS_END_BIT];
    assign usb_tx_en_o = r_reg.tx_en;
    assign usb_tx_dp_o = r_reg.tx_dp;
    assign usb_tx_se0_o = r_reg.tx_se0;
    assign mode_o = r_reg.mode;
    assign suspend_not_o = r_reg.func_ctrl[ulpi_lp_pkg::SUSPEND_NOT_BIT];
endmodule
`default_nettype wire

// ===== hdl/ulpi_lp_link.sv
// Purpose: Link end: register writes, wake and serial exit, 3-pin serial drive.
// Assumes: Software orders through a plain register port.
// Notes: Acts on falls of the synchronised interface clock; wake works unclocked.
`default_nettype none
module ulpi_lp_link (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    ulpi_lp_if.link bus,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o
);
    typedef enum logic [2:0] {L_IDLE, L_CMD, L_DATA, L_STP, L_WAKE, L_WAKE_DROP} lstate_t;

    typedef struct packed {
        lstate_t state;
        logic [ulpi_lp_pkg::CTRL_W-1:0] ctrl;
        logic pend;
        logic [5:0] reg_addr;
        logic [7:0] reg_data;
        logic stp;
        logic [7:0] dout;
        logic dir_prev;
        logic clk_d;
        logic [31:0] rdata;
    } link_t;

    link_t r_reg;
    link_t r_next;
    logic clk_s;
    logic dir_s;
    logic nxt_s;
    logic [7:0] data_s;
    logic fall;
    logic ser3;

    sync2 #(.W(11)) in_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i({bus.clk, bus.dir, bus.nxt, bus.data}),
        .q_o({clk_s, dir_s, nxt_s, data_s})
    );

    assign fall = r_reg.clk_d && !clk_s;
    assign ser3 = r_reg.ctrl[ulpi_lp_pkg::CTRL_SER3] && dir_s;

    always_comb begin
        r_next = r_reg;
        r_next.clk_d = clk_s;
        r_next.rdata = '0;
        if (fall) begin
            r_next.dir_prev = dir_s;
        end
        case (r_reg.state)
            L_IDLE: begin
                r_next.stp = 1'b0;
                r_next.dout = ulpi_lp_pkg::BUS_IDLE;
                if (r_reg.ctrl[ulpi_lp_pkg::CTRL_WAKE]) begin
                    r_next.stp = 1'b1;
                    r_next.state = L_WAKE;
                end else if (fall && r_reg.pend && !dir_s && !r_reg.dir_prev) begin
                    r_next.dout = {ulpi_lp_pkg::CMD_REGW, r_reg.reg_addr};
                    r_next.state = L_CMD;
                end
            end
            L_CMD: begin
                if (fall && nxt_s) begin
                    r_next.dout = r_reg.reg_data;
                    r_next.state = L_DATA;
                end
            end
            L_DATA: begin
                if (fall) begin
                    r_next.dout = ulpi_lp_pkg::BUS_IDLE;
                    r_next.stp = 1'b1;
                    r_next.pend = 1'b0;
                    r_next.state = L_STP;
                end
            end
            L_STP: begin
                if (fall) begin
                    r_next.stp = 1'b0;
                    r_next.state = L_IDLE;
                end
            end
            L_WAKE: begin
                if (!dir_s) begin
                    r_next.state = L_WAKE_DROP;
                end
            end
            L_WAKE_DROP: begin
                if (fall) begin
                    r_next.stp = 1'b0;
                    r_next.ctrl[ulpi_lp_pkg::CTRL_WAKE] = 1'b0;
                    r_next.state = L_IDLE;
                end
            end
            default: r_next.state = L_IDLE;
        endcase
        // Software writes come last so a set wins over the hardware clear
        if (wr_i) begin
            case (addr_i)
                ulpi_lp_pkg::LINK_CMD_ADDR: begin
                    r_next.reg_data = wdata_i[7:0];
                    r_next.reg_addr = wdata_i[ulpi_lp_pkg::CMD_ADDR_LSB +: 6];
                    r_next.pend = 1'b1;
                end
                ulpi_lp_pkg::LINK_CTRL_ADDR: r_next.ctrl = wdata_i[ulpi_lp_pkg::CTRL_W-1:0];
                default: r_next.pend = r_next.pend;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                ulpi_lp_pkg::LINK_CTRL_ADDR: r_next.rdata = {25'h0, r_reg.ctrl};
                ulpi_lp_pkg::LINK_STAT_ADDR: begin
                    r_next.rdata = {26'h0, r_reg.ctrl[ulpi_lp_pkg::CTRL_WAKE],
                                    data_s[2], data_s[1], dir_s & data_s[3],
                                    r_reg.pend || r_reg.state != L_IDLE, dir_s};
                end
                default: r_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    always_comb begin
        bus.link_oe = '0;
        bus.link_data = r_reg.dout;
        if (ser3) begin
            bus.link_data = {5'h00, r_reg.ctrl[ulpi_lp_pkg::CTRL_TX_SE0],
                             r_reg.ctrl[ulpi_lp_pkg::CTRL_TX_DP],
                             r_reg.ctrl[ulpi_lp_pkg::CTRL_TX_EN]};
            bus.link_oe = r_reg.ctrl[ulpi_lp_pkg::CTRL_TX_EN] ? ulpi_lp_pkg::LINK_OE_SER3_TX
                                                              : ulpi_lp_pkg::LINK_OE_SER3_RX;
        end else if (!dir_s && !r_reg.dir_prev) begin
            bus.link_oe = ulpi_lp_pkg::OE_ALL;
        end
    end

    assign bus.link_stp = r_reg.stp | r_reg.ctrl[ulpi_lp_pkg::CTRL_STP_HOLD];
    assign bus.link_stp_oe = ~r_reg.ctrl[ulpi_lp_pkg::CTRL_STP_FLOAT];
    assign rdata_o = r_reg.rdata;
endmodule
`default_nettype wire

// ===== tb/ulpi_lp_monitor.sv
// Purpose: Pin checks on the ULPI link joining both ends.
// Assumes: HALF matches the device clock divider.
// Notes: Clock counts as stopped when low for over a full period.
`default_nettype none
module ulpi_lp_monitor #(parameter int HALF = ulpi_lp_pkg::CLK_HALF_DIV) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk,
    input wire logic dir,
    input wire logic stp,
    input wire logic link_stp_oe,
    input wire logic [7:0] dev_oe,
    input wire logic [7:0] dev_data,
    input wire logic [7:0] link_oe
);
    logic [7:0] low_cnt;
    logic [3:0] rise_cnt;
    logic stopped;
    logic wake_req;
    assign stopped = low_cnt > 8'(2 * HALF);
    // Counters saturate so a long park never wraps into a false pass
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt <= 8'h00;
            rise_cnt <= 4'h0;
            wake_req <= 1'b0;
        end else begin
            // Stop held while parked or in serial; a write-end stop pulse never counts
            wake_req <= dir && stp && (wake_req || rise_cnt >= 4'h5);
            low_cnt <= clk ? 8'h00 : low_cnt + 8'(!(&low_cnt));
            rise_cnt <= !dir ? 4'h0 : rise_cnt + 4'($rose(clk) && !(&rise_cnt));
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence parked_idle;
        (dir && stopped && !stp) [*4];
    endsequence
    AST_ONE_OWNER: assert property (dir && dev_oe == 8'hFF |-> link_oe == 8'h00)
        else $error("data driven by both ends");
    AST_DEV_RELEASE: assert property (!dir |-> dev_oe == 8'h00)
        else $error("device drives data with direction low");
    AST_HIGH_LOW: assert property (dir |-> (dev_oe[7:4] & dev_data[7:4]) == 4'h0)
        else $error("upper data bits not low");
    AST_FIVE_RISES: assert property (dir && stopped |-> rise_cnt >= 4'h5)
        else $error("clock stopped too early");
    AST_PARKED: assert property (parked_idle |=> dir && !clk)
        else $error("device left park without stop");
    AST_WAKE: assert property ($rose(stp) && dir && stopped
        |-> ##[1:100] ($rose(clk) || !stp))
        else $error("clock not restarted on stop");
    AST_DIR_AT_RISE: assert property ($fell(dir) |-> clk || !stopped)
        else $error("direction released with clock stopped");
    AST_STP_HELD: assert property ($fell(stp) && link_stp_oe && wake_req |-> !dir)
        else $error("stop dropped before direction low");
endmodule
`default_nettype wire

// ===== tb/tb_ulpi_low_power_serial_ctl.sv
// Purpose: Drives the link register port and checks both ULPI ends.
// Assumes: Short start-up time keeps wake-up quick.
// Notes: Serial entries keep the clock so a reset pin pulse never drops direction mid-stop.
`default_nettype none
module tb_ulpi_low_power_serial_ctl;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b1, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, susp_not;
    logic active_low_reset_pin = 1'b1, rx_diff = 1'b0, rx_se0 = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, st;
    logic [3:0] irq_src = 4'h0;
    logic [2:0] tx;
    logic [1:0] cmp, ls = 2'h0;
    ulpi_lp_pkg::mode_t mode;
    int err_count = 0, checks = 0;
    ulpi_lp_if ulpi_lp_if_i ();
    ulpi_lp_device #(.START_TIME_NS(40)) ulpi_lp_device_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .bus(ulpi_lp_if_i), .active_low_reset_pin_i(active_low_reset_pin), .irq_src_i(irq_src),
        .linestate_i(ls), .rx_diff_i(rx_diff), .rx_se0_i(rx_se0), .usb_tx_en_o(tx[2]),
        .usb_tx_dp_o(tx[1]), .usb_tx_se0_o(tx[0]), .bus_voltage_valid_comparator_en_o(cmp[1]),
        .session_end_comparator_en_o(cmp[0]), .mode_o(mode), .suspend_not_o(susp_not));
    ulpi_lp_link ulpi_lp_link_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(ulpi_lp_if_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    ulpi_lp_monitor ulpi_lp_monitor_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .clk(ulpi_lp_if_i.clk), .dir(ulpi_lp_if_i.dir), .stp(ulpi_lp_if_i.stp),
        .link_stp_oe(ulpi_lp_if_i.link_stp_oe), .dev_oe(ulpi_lp_if_i.dev_oe),
        .dev_data(ulpi_lp_if_i.dev_data), .link_oe(ulpi_lp_if_i.link_oe));
    initial forever #2 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    // Polls status until the masked bits match, bounded
    task automatic wt(input logic [31:0] m, input logic [31:0] v);
        st = ~v;
        for (int i = 0; i < 300 && (st & m) !== v; i++) rd(ulpi_lp_pkg::LINK_STAT_ADDR, st);
        chk(st & m, v);
    endtask
    task automatic uw(input logic [5:0] a, input logic [7:0] d);
        wr(ulpi_lp_pkg::LINK_CMD_ADDR, {18'h0, a, d});
        wt(32'h2, 32'h0);
    endtask
    task automatic test_done;
        $display("Checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #200us;
        err_count++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        chk(ulpi_lp_if_i.stp_pullup_en, 32'h1);
        uw(ulpi_lp_pkg::FUNC_CTRL_ADDR, 8'h01);
        wt(32'h1, 32'h1);
        chk({susp_not, mode}, {1'b0, ulpi_lp_pkg::MODE_LOWPWR});
        repeat (200) @(posedge ref_clk_i);
        chk(ulpi_lp_if_i.stp, 32'h0);
        wr(ulpi_lp_pkg::LINK_CTRL_ADDR, 32'h1);
        wt(32'h23, 32'h0);
        chk({susp_not, mode}, {1'b1, ulpi_lp_pkg::MODE_SYNC});
        // Stop floated: the pull-up alone must wake the parked end
        uw(ulpi_lp_pkg::FUNC_CTRL_ADDR, 8'h01);
        wt(32'h1, 32'h1);
        repeat (200) @(posedge ref_clk_i);
        wr(ulpi_lp_pkg::LINK_CTRL_ADDR, 32'h4);
        wt(32'h1, 32'h0);
        wr(ulpi_lp_pkg::LINK_CTRL_ADDR, 32'h0);
        // Stop low must reach the far end before the next command goes out
        repeat (20) @(posedge ref_clk_i);
        chk({susp_not, mode}, {1'b1, ulpi_lp_pkg::MODE_SYNC});
        $display("Low power test done");
        uw(ulpi_lp_pkg::FUNC_CTRL_ADDR, ulpi_lp_pkg::FUNC_CTRL_RST);
        wr(ulpi_lp_pkg::LINK_CTRL_ADDR, 32'h40);
        uw(ulpi_lp_pkg::IFC_CTRL_ADDR, 8'h0A);
        wt(32'h1, 32'h1);
        chk(mode, ulpi_lp_pkg::MODE_SERIAL3);
        wt(32'h1C, 32'h10);
        @(posedge ref_clk_i);
        rx_diff <= 1'b1;
        rx_se0 <= 1'b1;
        irq_src <= 4'h1;
        wt(32'h1C, 32'h0C);
        wr(ulpi_lp_pkg::LINK_CTRL_ADDR, 32'h78);
        st = 32'h0;
        repeat (40) @(posedge ref_clk_i) st = st | ulpi_lp_if_i.clk;
        chk(st, 32'h1);
        chk(tx, 3'h7);
        wr(ulpi_lp_pkg::LINK_CTRL_ADDR, 32'h41);
        wt(32'h23, 32'h0);
        chk(mode, ulpi_lp_pkg::MODE_SYNC);
        $display("Serial test done");
        uw(ulpi_lp_pkg::IRQ_RISE_ADDR, 8'h0A);
        chk(cmp, 2'h3);
        uw(ulpi_lp_pkg::IRQ_FALL_ADDR, 8'h0A);
        chk(cmp, 2'h0);
        $display("Comparator test done");
        uw(ulpi_lp_pkg::IFC_CTRL_ADDR, 8'h0A);
        wt(32'h1, 32'h1);
        @(posedge ref_clk_i);
        active_low_reset_pin <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        chk({ulpi_lp_if_i.stp_pullup_en, ulpi_lp_if_i.dir, mode}, 4'h0);
        active_low_reset_pin <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        uw(ulpi_lp_pkg::IFC_CTRL_ADDR, 8'h80);
        chk(ulpi_lp_if_i.stp_pullup_en, 32'h0);
        $display("Reset pin test done");
        // Link leaves the 3-pin map so a receive command owns the whole bus
        wr(ulpi_lp_pkg::LINK_CTRL_ADDR, 32'h0);
        ls <= 2'h1;
        wt(32'h1, 32'h1);
        wt(32'h3, 32'h0);
        chk({tx, mode}, 5'h00);
        $display("Receive command test done");
        test_done;
    end
endmodule
`default_nettype wire
